// File: verilog/agor_map.svh
// Purpose: Register map, field positions and reset values of the gain/offset register bank.
// Assumes: AHB-Lite word access, byte address equals four times the register index.
// Notes:   Definitions only.
// Functional notes
// - With gain enabled, channel 6 samples get N x 0.2 dB gain, N taken from bits 15-11.
// - The gain code is unsigned and each step adds 0.2 dB.
// - With gain enabled, channel 7 takes its gain code from bits 15-11 at index 1Dh.
// - With offset enabled, the channel 6 offset in bits 9-0 is added to its samples.
// - Each offset is 10-bit two's complement, one LSB equal to one LSB of a 14-bit word.
// - With offset enabled, the channel 7 offset in bits 9-0 is added to its samples.
// - The channel 6 mirror at index 1Ch holds its copy in bits 9-0, bits 15-10 unused.
// - All fields of these registers are read/write and reset to zero.
`ifndef AGOR_MAP_SVH
`define AGOR_MAP_SVH
// ****************************************************************
// Register indices (byte address = index * 4)
// ****************************************************************
`define AGOR_IDX_CH6_GO 6'h1b
`define AGOR_IDX_CH6_MIR 6'h1c
`define AGOR_IDX_CH7_GO 6'h1d
`define AGOR_IDX_CH7_MIR 6'h1e
`define AGOR_IDX_CTRL 6'h30
`define AGOR_IDX_STAT 6'h31
`define AGOR_IDX_MSB 7
`define AGOR_IDX_LSB 2
`define AGOR_ADDR_TOP 31
`define AGOR_ADDR_LOW_ZERO 2'h0
`define AGOR_ADDR_HIGH_ZERO 24'h000000
// ****************************************************************
// Fields and reset values
// ****************************************************************
`define AGOR_GAIN_MSB 15
`define AGOR_GAIN_LSB 11
`define AGOR_OFFS_MSB 9
`define AGOR_OFFS_LSB 0
`define AGOR_REG_RESET 16'h0000
`define AGOR_CTRL_RESET 2'h0
`define AGOR_CTRL_GAIN_EN 0
`define AGOR_CTRL_OFFS_EN 1
`define AGOR_STAT_MIS6 0
`define AGOR_STAT_MIS7 1
`define AGOR_HSIZE_WORD 3'h2
`define AGOR_HTRANS_NONSEQ 2'h2
`define AGOR_GAIN_UNITY 17'h04000
`define AGOR_GAIN_FRAC 14
`endif

// File: verilog/agor_pkg.sv
// Purpose: Types shared by the gain/offset register bank.
// Assumes: Nothing beyond the map header.
// Notes:   Register select codes and the bank state record.
package agor_pkg;
  typedef enum logic [2:0] {
    AGOR_SEL_NONE = 3'h0,
    AGOR_SEL_CH6_GO = 3'h1,
    AGOR_SEL_CH6_MIR = 3'h2,
    AGOR_SEL_CH7_GO = 3'h3,
    AGOR_SEL_CH7_MIR = 3'h4,
    AGOR_SEL_CTRL = 3'h5,
    AGOR_SEL_STAT = 3'h6
  } agor_sel_t;

  typedef struct packed {
    logic dp_wr;
    logic dp_rd;
    agor_sel_t dp_sel;
    logic [15:0] ch6_go;
    logic [15:0] ch6_mir;
    logic [15:0] ch7_go;
    logic [15:0] ch7_mir;
    logic [1:0] ctrl;
    logic [31:0] rdata;
  } agor_state_t;
endpackage

// File: verilog/agor_chan.sv
// Purpose: One channel of digital gain and offset correction on 14-bit samples.
// Assumes: Gain code and offset are static while samples flow; two-cycle latency.
// Notes:   Gain uses a fixed-point table of 10^(N*0.01); results saturate.
`timescale 1ns/100ps
`include "agor_map.svh"
module agor_chan #(
  parameter int SAMPLE_W = 14,
  parameter int GAIN_W = 5,
  parameter int OFFS_W = 10
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic gain_enable,
  input wire logic offset_enable,
  input wire logic [GAIN_W-1:0] gain_steps,
  input wire logic [OFFS_W-1:0] offset_value,
  input wire logic in_valid,
  input wire logic signed [SAMPLE_W-1:0] in_data,
  output logic out_valid,
  output logic signed [SAMPLE_W-1:0] out_data
);
  localparam int PW = SAMPLE_W + 18;
  localparam logic signed [SAMPLE_W+3:0] SMAX = (SAMPLE_W+4)'(2 ** (SAMPLE_W - 1) - 1);
  localparam logic signed [SAMPLE_W+3:0] SMIN = -(SAMPLE_W+4)'(2 ** (SAMPLE_W - 1));
  // Linear factors of 0.2 dB steps, unity at 17'h04000
  localparam logic [16:0] GTAB [32] = '{
    17'h04000, 17'h0417e, 17'h04304, 17'h04494, 17'h0462d, 17'h047cf, 17'h0497b, 17'h04b32,
    17'h04cf2, 17'h04ebd, 17'h05092, 17'h05273, 17'h0545e, 17'h05655, 17'h05858, 17'h05a67,
    17'h05c82, 17'h05eaa, 17'h060de, 17'h06320, 17'h0656f, 17'h067cc, 17'h06a37, 17'h06cb0,
    17'h06f38, 17'h071cf, 17'h07476, 17'h0772c, 17'h079f3, 17'h07cca, 17'h07fb2, 17'h082ac
  };

  typedef struct packed {
    logic s1_valid;
    logic signed [SAMPLE_W+3:0] s1_data;
    logic out_valid;
    logic signed [SAMPLE_W-1:0] out_data;
  } agor_chan_state_t;

  agor_chan_state_t st_q;
  agor_chan_state_t st_d;

  always_comb
  begin
    logic signed [17:0] factor;
    logic signed [PW-1:0] prod;
    logic signed [SAMPLE_W+3:0] sum;
    factor = 18'($signed({1'b0, `AGOR_GAIN_UNITY}));
    prod = '0;
    sum = '0;
    st_d = st_q;
    if (gain_enable)
    begin
      factor = 18'($signed({1'b0, GTAB[gain_steps]}));
    end
    prod = PW'(in_data) * PW'(factor);
    st_d.s1_valid = in_valid;
    st_d.s1_data = (SAMPLE_W+4)'(prod >>> `AGOR_GAIN_FRAC);
    sum = st_q.s1_data;
    if (offset_enable)
    begin
      sum = st_q.s1_data + (SAMPLE_W+4)'($signed(offset_value));
    end
    st_d.out_valid = st_q.s1_valid;
    if (sum > SMAX)
    begin
      st_d.out_data = SAMPLE_W'(SMAX);
    end
    else if (sum < SMIN)
    begin
      st_d.out_data = SAMPLE_W'(SMIN);
    end
    else
    begin
      st_d.out_data = SAMPLE_W'(sum);
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign out_valid = st_q.out_valid;
  assign out_data = st_q.out_data;
endmodule

// File: verilog/agor_regs.sv
// Purpose: Gain/offset register bank for channels 6 and 7 with the correction datapaths.
// Assumes: Single AHB-Lite master, whole-word transfers, zero wait states.
// Notes:   Read data are captured at the address phase from the post-write register values.
`timescale 1ns/100ps
`include "agor_map.svh"
module agor_regs #(
  parameter int SAMPLE_W = 14
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic ch6_in_valid,
  input wire logic signed [SAMPLE_W-1:0] ch6_in_data,
  output logic ch6_out_valid,
  output logic signed [SAMPLE_W-1:0] ch6_out_data,
  input wire logic ch7_in_valid,
  input wire logic signed [SAMPLE_W-1:0] ch7_in_data,
  output logic ch7_out_valid,
  output logic signed [SAMPLE_W-1:0] ch7_out_data
);
  agor_pkg::agor_state_t st_q;
  agor_pkg::agor_state_t st_d;
  logic addr_phase;
  agor_pkg::agor_sel_t sel;
  logic digital_gain_enable;
  logic digital_offset_enable;
  logic [4:0] sixth_channel_gain_steps;
  logic [4:0] seventh_channel_gain_steps;
  logic [9:0] sixth_channel_offset_value;
  logic [9:0] seventh_channel_offset_value;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  assign addr_phase = hsel && hready && (htrans == `AGOR_HTRANS_NONSEQ);

  always_comb
  begin
    logic [5:0] idx;
    idx = haddr[`AGOR_IDX_MSB:`AGOR_IDX_LSB];
    if (haddr[`AGOR_IDX_LSB-1:0] != `AGOR_ADDR_LOW_ZERO)
    begin
      sel = agor_pkg::AGOR_SEL_NONE;
    end
    else if (haddr[`AGOR_ADDR_TOP:`AGOR_IDX_MSB+1] != `AGOR_ADDR_HIGH_ZERO)
    begin
      sel = agor_pkg::AGOR_SEL_NONE;
    end
    else if (idx == `AGOR_IDX_CH6_GO)
    begin
      sel = agor_pkg::AGOR_SEL_CH6_GO;
    end
    else if (idx == `AGOR_IDX_CH6_MIR)
    begin
      sel = agor_pkg::AGOR_SEL_CH6_MIR;
    end
    else if (idx == `AGOR_IDX_CH7_GO)
    begin
      sel = agor_pkg::AGOR_SEL_CH7_GO;
    end
    else if (idx == `AGOR_IDX_CH7_MIR)
    begin
      sel = agor_pkg::AGOR_SEL_CH7_MIR;
    end
    else if (idx == `AGOR_IDX_CTRL)
    begin
      sel = agor_pkg::AGOR_SEL_CTRL;
    end
    else if (idx == `AGOR_IDX_STAT)
    begin
      sel = agor_pkg::AGOR_SEL_STAT;
    end
    else
    begin
      sel = agor_pkg::AGOR_SEL_NONE;
    end
  end

  // ****************************************************************
  // Register state
  // ****************************************************************
  always_comb
  begin
    st_d = st_q;
    st_d.dp_wr = 1'b0;
    st_d.dp_rd = 1'b0;
    // Whole-word write lands in the data phase; bits 15-0 are stored (bits 1-0 for control), the upper half is dropped
    if (st_q.dp_wr)
    begin
      case (st_q.dp_sel)
        agor_pkg::AGOR_SEL_CH6_GO: st_d.ch6_go = hwdata[15:0];
        agor_pkg::AGOR_SEL_CH6_MIR: st_d.ch6_mir = hwdata[15:0];
        agor_pkg::AGOR_SEL_CH7_GO: st_d.ch7_go = hwdata[15:0];
        agor_pkg::AGOR_SEL_CH7_MIR: st_d.ch7_mir = hwdata[15:0];
        agor_pkg::AGOR_SEL_CTRL: st_d.ctrl = hwdata[1:0];
        default: st_d.ctrl = st_q.ctrl;
      endcase
    end
    if (addr_phase)
    begin
      st_d.dp_sel = sel;
      st_d.dp_wr = hwrite && (hsize == `AGOR_HSIZE_WORD);
      st_d.dp_rd = !hwrite;
      // Read from the updated values so a read right behind a write sees it
      if (!hwrite)
      begin
        case (sel)
          agor_pkg::AGOR_SEL_CH6_GO: st_d.rdata = {16'h0000, st_d.ch6_go};
          agor_pkg::AGOR_SEL_CH6_MIR: st_d.rdata = {16'h0000, st_d.ch6_mir};
          agor_pkg::AGOR_SEL_CH7_GO: st_d.rdata = {16'h0000, st_d.ch7_go};
          agor_pkg::AGOR_SEL_CH7_MIR: st_d.rdata = {16'h0000, st_d.ch7_mir};
          agor_pkg::AGOR_SEL_CTRL: st_d.rdata = {30'h00000000, st_d.ctrl};
          agor_pkg::AGOR_SEL_STAT:
          begin
            st_d.rdata = 32'h00000000;
            st_d.rdata[`AGOR_STAT_MIS6] = st_d.ch6_go[`AGOR_OFFS_MSB:`AGOR_OFFS_LSB] !=
                                          st_d.ch6_mir[`AGOR_OFFS_MSB:`AGOR_OFFS_LSB];
            st_d.rdata[`AGOR_STAT_MIS7] = st_d.ch7_go[`AGOR_OFFS_MSB:`AGOR_OFFS_LSB] !=
                                          st_d.ch7_mir[`AGOR_OFFS_MSB:`AGOR_OFFS_LSB];
          end
          default: st_d.rdata = 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      st_q.dp_wr <= 1'b0;
      st_q.dp_rd <= 1'b0;
      st_q.dp_sel <= agor_pkg::AGOR_SEL_NONE;
      st_q.ch6_go <= `AGOR_REG_RESET;
      st_q.ch6_mir <= `AGOR_REG_RESET;
      st_q.ch7_go <= `AGOR_REG_RESET;
      st_q.ch7_mir <= `AGOR_REG_RESET;
      st_q.ctrl <= `AGOR_CTRL_RESET;
      st_q.rdata <= 32'h00000000;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // No wait states and no error responses: unmapped words read zero
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st_q.rdata;

  // ****************************************************************
  // Field extraction and datapaths
  // ****************************************************************
  assign digital_gain_enable = st_q.ctrl[`AGOR_CTRL_GAIN_EN];
  assign digital_offset_enable = st_q.ctrl[`AGOR_CTRL_OFFS_EN];
  assign sixth_channel_gain_steps = st_q.ch6_go[`AGOR_GAIN_MSB:`AGOR_GAIN_LSB];
  assign seventh_channel_gain_steps = st_q.ch7_go[`AGOR_GAIN_MSB:`AGOR_GAIN_LSB];
  // Mirrors are kept for software only; the main registers drive the adders
  assign sixth_channel_offset_value = st_q.ch6_go[`AGOR_OFFS_MSB:`AGOR_OFFS_LSB];
  assign seventh_channel_offset_value = st_q.ch7_go[`AGOR_OFFS_MSB:`AGOR_OFFS_LSB];

  agor_chan #(
    .SAMPLE_W(SAMPLE_W)
  ) u_ch6 (
    .clock(clock),
    .rst(rst),
    .gain_enable(digital_gain_enable),
    .offset_enable(digital_offset_enable),
    .gain_steps(sixth_channel_gain_steps),
    .offset_value(sixth_channel_offset_value),
    .in_valid(ch6_in_valid),
    .in_data(ch6_in_data),
    .out_valid(ch6_out_valid),
    .out_data(ch6_out_data)
  );

  agor_chan #(
    .SAMPLE_W(SAMPLE_W)
  ) u_ch7 (
    .clock(clock),
    .rst(rst),
    .gain_enable(digital_gain_enable),
    .offset_enable(digital_offset_enable),
    .gain_steps(seventh_channel_gain_steps),
    .offset_value(seventh_channel_offset_value),
    .in_valid(ch7_in_valid),
    .in_data(ch7_in_data),
    .out_valid(ch7_out_valid),
    .out_data(ch7_out_data)
  );

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  logic ch6_go_wr;
  logic ch7_go_wr;
  logic ch6_mir_rd_q;
  logic signed [SAMPLE_W-1:0] ch6_offs_ext;
  logic signed [SAMPLE_W-1:0] ch7_offs_ext;
  assign ch6_go_wr = st_q.dp_wr && (st_q.dp_sel == agor_pkg::AGOR_SEL_CH6_GO);
  assign ch7_go_wr = st_q.dp_wr && (st_q.dp_sel == agor_pkg::AGOR_SEL_CH7_GO);
  assign ch6_offs_ext = SAMPLE_W'($signed(sixth_channel_offset_value));
  assign ch7_offs_ext = SAMPLE_W'($signed(seventh_channel_offset_value));

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      ch6_mir_rd_q <= 1'b0;
    end
    else
    begin
      ch6_mir_rd_q <= addr_phase && !hwrite && (sel == agor_pkg::AGOR_SEL_CH6_MIR);
    end
  end

  a_ch6_gain_latency: assert property (
    ch6_in_valid && digital_gain_enable && $stable(st_q.ch6_go)
    |-> ##2 ch6_out_valid)
    else $error("channel 6 output not valid two cycles after input");

  a_unity_gain_zero: assert property (
    ch6_in_valid && !digital_offset_enable && (sixth_channel_gain_steps == 5'h00)
    ##1 !digital_offset_enable
    |-> ##1 ch6_out_data == $past(ch6_in_data, 2))
    else $error("zero gain code changed the channel 6 sample");

  a_gain_grows_up: assert property (
    ch6_in_valid && digital_gain_enable && !digital_offset_enable &&
    // Small samples round back to themselves and large ones saturate
    (sixth_channel_gain_steps != 5'h00) && (ch6_in_data >= 14'sh0040) && (ch6_in_data <= 14'sh0fa0)
    ##1 !digital_offset_enable
    |-> ##1 ch6_out_data > $past(ch6_in_data, 2))
    else $error("nonzero gain code did not raise a positive sample");

  a_ch7_gain_field: assert property (
    ch7_go_wr |=> seventh_channel_gain_steps == $past(hwdata[15:11]))
    else $error("channel 7 gain code not taken from bits 15-11");

  a_ch6_offs_add: assert property (
    ch6_in_valid && (ch6_in_data == '0) && !digital_gain_enable && digital_offset_enable
    ##1 digital_offset_enable && $stable(st_q.ch6_go)
    |-> ##1 ch6_out_data == $past(ch6_offs_ext))
    else $error("channel 6 offset not added to a zero sample");

  a_neg_offs_sign: assert property (
    ch7_in_valid && (ch7_in_data == '0) && !digital_gain_enable && digital_offset_enable &&
    seventh_channel_offset_value[9]
    ##1 digital_offset_enable && $stable(st_q.ch7_go)
    |-> ##1 ch7_out_data[SAMPLE_W-1])
    else $error("negative channel 7 offset gave a non-negative result");

  a_ch7_offs_add: assert property (
    ch7_in_valid && (ch7_in_data == '0) && !digital_gain_enable && digital_offset_enable
    ##1 digital_offset_enable && $stable(st_q.ch7_go)
    |-> ##1 ch7_out_data == $past(ch7_offs_ext))
    else $error("channel 7 offset not added to a zero sample");

  a_mirror_read_back: assert property (
    ch6_mir_rd_q |-> hrdata[9:0] == st_q.ch6_mir[9:0])
    else $error("channel 6 mirror read returned the wrong offset copy");

  a_write_store_all: assert property (
    ch6_go_wr |=> st_q.ch6_go == $past(hwdata[15:0]) ##1 $stable(st_q.ch6_go) || $past(ch6_go_wr))
    else $error("channel 6 gain/offset write not stored in full");

  a_reset_all_zero: assert property (
    $past(rst) |-> (st_q.ch6_go == '0) && (st_q.ch6_mir == '0) && (st_q.ch7_go == '0) &&
    (st_q.ch7_mir == '0))
    else $error("registers not zero after reset");

  // ****************************************************************
  // Field, bus and pipeline assertions
  // ****************************************************************
  a_ch6_gain_field: assert property (
    ch6_go_wr |=> sixth_channel_gain_steps == $past(hwdata[15:11]))
    else $error("channel 6 gain code not taken from bits 15-11");

  a_ch6_offs_field: assert property (
    ch6_go_wr |=> sixth_channel_offset_value == $past(hwdata[9:0]))
    else $error("channel 6 offset not taken from bits 9-0");

  a_ch7_offs_field: assert property (
    ch7_go_wr |=> seventh_channel_offset_value == $past(hwdata[9:0]))
    else $error("channel 7 offset not taken from bits 9-0");

  a_mirror_no_effect: assert property (
    st_q.dp_wr && (st_q.dp_sel == agor_pkg::AGOR_SEL_CH6_MIR)
    |=> $stable(sixth_channel_offset_value))
    else $error("channel 6 mirror write moved the applied offset");

  a_ch7_mirror_inert: assert property (
    st_q.dp_wr && (st_q.dp_sel == agor_pkg::AGOR_SEL_CH7_MIR)
    |=> $stable(seventh_channel_offset_value))
    else $error("channel 7 mirror write moved the applied offset");

  a_ch7_mirror_read: assert property (
    st_q.dp_rd && (st_q.dp_sel == agor_pkg::AGOR_SEL_CH7_MIR)
    |-> hrdata == {16'h0000, st_q.ch7_mir})
    else $error("channel 7 mirror read returned the wrong value");

  a_upper_reads_zero: assert property (
    st_q.dp_rd |-> hrdata[31:16] == 16'h0000)
    else $error("upper half of read data not zero");

  a_unmapped_read_zero: assert property (
    st_q.dp_rd && (st_q.dp_sel == agor_pkg::AGOR_SEL_NONE)
    |-> hrdata == 32'h00000000)
    else $error("unmapped read did not return zero");

  a_narrow_write_drop: assert property (
    addr_phase && hwrite && (hsize != `AGOR_HSIZE_WORD) |=> !st_q.dp_wr)
    else $error("non-word write was armed for storage");

  a_ctrl_reset_zero: assert property (
    $past(rst) |-> st_q.ctrl == `AGOR_CTRL_RESET)
    else $error("enable bits not zero after reset");

  a_gain_off_unity: assert property (
    ch7_in_valid && !digital_gain_enable && !digital_offset_enable ##1 !digital_offset_enable
    |-> ##1 ch7_out_data == $past(ch7_in_data, 2))
    else $error("channel 7 sample changed with both corrections off");

  a_ch7_valid_latency: assert property (
    ch7_in_valid |-> ##2 ch7_out_valid)
    else $error("channel 7 output not valid two cycles after input");

  a_ch7_status_flag: assert property (
    st_q.dp_rd && (st_q.dp_sel == agor_pkg::AGOR_SEL_STAT)
    |-> hrdata[`AGOR_STAT_MIS7] == (st_q.ch7_go[9:0] != st_q.ch7_mir[9:0]))
    else $error("channel 7 mismatch flag read wrong");

  c_status_mismatch: cover property (
    st_q.dp_rd && (st_q.dp_sel == agor_pkg::AGOR_SEL_STAT) && hrdata[`AGOR_STAT_MIS7]);
  c_gain_applied: cover property (
    ch6_in_valid && digital_gain_enable && (sixth_channel_gain_steps == 5'h1f));
  c_offset_applied: cover property (
    ch7_in_valid && digital_offset_enable && seventh_channel_offset_value[9]);
  c_read_after_write: cover property (
    ch6_go_wr && addr_phase && !hwrite && (sel == agor_pkg::AGOR_SEL_CH6_GO));
  c_unmapped_read: cover property (
    addr_phase && !hwrite && (sel == agor_pkg::AGOR_SEL_NONE));
endmodule

// File: test/agor_regs_tb.sv
// Purpose: Self-checking bench for the channel 6/7 gain/offset register bank.
// Assumes: Zero-wait AHB-Lite slave, sample latency of two edges, gain table 10^(N*0.01).
// Notes:   Bench is the bus master and the sample source; no separate partner model.
`timescale 1ns/100ps
module agor_regs_tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h00000000;
  wire logic hready;
  logic hresp;
  logic [31:0] hrdata;
  logic ch6_in_valid = 1'b0;
  logic signed [13:0] ch6_in_data = 14'h0000;
  logic ch6_out_valid;
  logic signed [13:0] ch6_out_data;
  logic ch7_in_valid = 1'b0;
  logic signed [13:0] ch7_in_data = 14'h0000;
  logic ch7_out_valid;
  logic signed [13:0] ch7_out_data;
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [31:0] rd;
  // ****************************************************************
  // Byte addresses: printed offsets are indices, times four
  // ****************************************************************
  localparam logic [31:0] A6 = 32'h0000006c;
  localparam logic [31:0] M6 = 32'h00000070;
  localparam logic [31:0] A7 = 32'h00000074;
  localparam logic [31:0] M7 = 32'h00000078;
  localparam logic [31:0] CT = 32'h000000c0;
  localparam logic [31:0] ST = 32'h000000c4;

  agor_regs #(.SAMPLE_W(14)) i_dut (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .ch6_in_valid(ch6_in_valid),
    .ch6_in_data(ch6_in_data), .ch6_out_valid(ch6_out_valid), .ch6_out_data(ch6_out_data),
    .ch7_in_valid(ch7_in_valid), .ch7_in_data(ch7_in_data), .ch7_out_valid(ch7_out_valid),
    .ch7_out_data(ch7_out_data));

  initial
  begin
    forever #4 clock = ~clock;
  end

  // Whole run needs a few hundred cycles; the ceiling leaves wide margin
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      $display("BAD %0t timeout", $time);
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // ****************************************************************
  // Bus master
  // ****************************************************************
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                     input logic [2:0] sz, output logic [31:0] r);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= sz;
    do @(posedge clock); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clock); while (hready !== 1'b1);
    r = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    logic [31:0] r;
    bus(1'b1, a, {16'h0000, d}, 3'h2, r);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h00000000, 3'h2, rd);
    chk(rd, exp, "read");
  endtask

  // ****************************************************************
  // Sample path
  // ****************************************************************
  function automatic int expect_out(int x, int n, logic [9:0] off, logic [1:0] en);
    int g;
    int y;
    g = en[0] ? int'(16384.0 * (10.0 ** (n * 0.01))) : 16384;
    y = (x * g) >>> 14;
    if (en[1])
      y = y + int'($signed(off));
    if (y > 8191)
      y = 8191;
    if (y < -8192)
      y = -8192;
    return y;
  endfunction

  task automatic run(input logic [1:0] en, input logic [4:0] n6, input logic [9:0] o6,
                     input logic [4:0] n7, input logic [9:0] o7, input int x6, input int x7);
    logic [13:0] e6;
    logic [13:0] e7;
    wr(A6, {n6, 1'b0, o6});
    wr(M6, {6'h00, o6});
    wr(A7, {n7, 1'b0, o7});
    wr(M7, {6'h00, o7});
    wr(CT, {14'h0000, en});
    e6 = 14'(expect_out(x6, n6, o6, en));
    e7 = 14'(expect_out(x7, n7, o7, en));
    @(posedge clock);
    ch6_in_valid <= 1'b1;
    ch6_in_data <= 14'(x6);
    ch7_in_valid <= 1'b1;
    ch7_in_data <= 14'(x7);
    @(posedge clock);
    ch6_in_valid <= 1'b0;
    ch7_in_valid <= 1'b0;
    #1;
    chk({30'h0, ch6_out_valid, ch7_out_valid}, 32'h00000000, "early valid");
    @(posedge clock);
    #1;
    chk({30'h0, ch6_out_valid, ch7_out_valid}, 32'h00000003, "valid");
    chk({18'h0, ch6_out_data}, {18'h0, e6}, "ch6 sample");
    chk({18'h0, ch7_out_data}, {18'h0, e7}, "ch7 sample");
    @(posedge clock);
    #1;
    chk({30'h0, ch6_out_valid, ch7_out_valid}, 32'h00000000, "valid dropped");
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic test_reset();
    rd_chk(A6, 32'h00000000);
    rd_chk(M6, 32'h00000000);
    rd_chk(A7, 32'h00000000);
    rd_chk(M7, 32'h00000000);
    rd_chk(CT, 32'h00000000);
    chk({31'h0, hresp}, 32'h00000000, "okay");
    $display("test reset done");
  endtask

  task automatic test_rw();
    logic [31:0] r;
    wr(A6, 16'hfbff);
    wr(M6, 16'h03ff);
    wr(A7, 16'ha955);
    wr(M7, 16'h0155);
    rd_chk(A6, 32'h0000fbff);
    rd_chk(M6, 32'h000003ff);
    rd_chk(A7, 32'h0000a955);
    rd_chk(M7, 32'h00000155);
    rd_chk(ST, 32'h00000000);
    wr(M7, 16'h0154);
    rd_chk(ST, 32'h00000002);
    wr(M7, 16'h0155);
    // Byte-sized write must leave the register alone
    bus(1'b1, A7, 32'h00000000, 3'h0, r);
    rd_chk(A7, 32'h0000a955);
    wr(32'h00000100, 16'hffff);
    rd_chk(32'h00000100, 32'h00000000);
    $display("test rw done");
  endtask

  task automatic test_offset();
    // Gain code present but gain disabled: only offsets act
    run(2'h2, 5'h0a, 10'h3f6, 5'h0a, 10'h1ff, 100, 100);
    run(2'h2, 5'h00, 10'h200, 5'h00, 10'h001, -8000, 8191);
    run(2'h2, 5'h03, 10'h155, 5'h03, 10'h2aa, 0, 0);
    $display("test offset done");
  endtask

  task automatic test_gain();
    logic [4:0] codes [4] = '{5'h00, 5'h01, 5'h05, 5'h1f};
    foreach (codes[i])
      run(2'h1, codes[i], 10'h3f6, codes[i], 10'h1ff, 1000, -1000);
    run(2'h3, 5'h05, 10'h3f6, 5'h1f, 10'h001, 1000, -1000);
    run(2'h0, 5'h1f, 10'h1ff, 5'h1f, 10'h200, 1234, -1234);
    $display("test gain done");
  endtask

  // Reset again with the four channel registers holding live values; control is already zero
  task automatic test_mid_reset();
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    test_reset();
    $display("test mid reset done");
  endtask

  initial
  begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    test_reset();
    test_rw();
    test_offset();
    test_gain();
    test_mid_reset();
    give_verdict();
  end
endmodule
